// *** hdl/ppao_pkg.sv ***
// Shared constants for the port pin alternate override block.
package ppao_pkg;

  // ****************************************************************
  // Port geometry
  // ****************************************************************
  // Pins in one port.
  localparam int PORT_W = 8;
  // Lowest pin that has an alternate function in this block.
  localparam int ALT_LO = 3;
  // Positions of the pins with alternate functions.
  localparam int BIT_OSC_OUT = 7;
  localparam int BIT_OSC_IN = 6;
  localparam int BIT_SCK = 5;
  localparam int BIT_MISO = 4;
  localparam int BIT_MOSI = 3;
  // Number of pin change sources fed by this block.
  localparam int PCS_W = PORT_W - ALT_LO;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  // Direction, output and input bits clear at reset: all pins float.
  localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
  localparam logic [PORT_W-1:0] OUT_RST = 8'h00;
  localparam logic [PORT_W-1:0] PIN_RST = 8'h00;
  localparam logic [PORT_W-1:0] RD_RST = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // Clock edges from pad to readable input bit.
  localparam int SYNC_CYCLES = 2;

endpackage : ppao_pkg

// *** hdl/ppao_pin_cell.sv ***
// One pin's override combination between port registers and the pad.
`timescale 1ns/10ps
module ppao_pin_cell (
  // Port register bits of this pin.
  input wire logic pin_direction_bit,
  input wire logic pin_output_bit,
  // Signals common to all ports.
  input wire logic global_pullup_disable,
  input wire logic sleep_clamp,
  // Per-pin overrides from alternate modules.
  input wire logic pullup_override_en,
  input wire logic pullup_override_val,
  input wire logic direction_override_en,
  input wire logic direction_override_val,
  input wire logic outvalue_override_en,
  input wire logic outvalue_override_val,
  input wire logic input_enable_override_en,
  input wire logic input_enable_override_val,
  // Pad side.
  input wire logic pad_in,
  output logic pad_oe,
  output logic pad_out,
  output logic pad_pullup,
  output logic raw_digital_input
);

  logic in_en;

  // All paths are combinational so an override reaches the pad at once.
  always_comb begin
    // Pull-up from the port bits, unless an alternate module owns it.
    if (pullup_override_en) begin
      pad_pullup = pullup_override_val;
    end else begin
      pad_pullup = ({pin_direction_bit, pin_output_bit,
                     global_pullup_disable} == 3'b010);
    end
    // Direction bit one means output, unless overridden.
    pad_oe = direction_override_en ? direction_override_val
                                   : pin_direction_bit;
    // Driven level; it only matters while the driver is on.
    pad_out = outvalue_override_en ? outvalue_override_val
                                   : pin_output_bit;
    // Sleep clamps the input buffer unless an override keeps it open.
    in_en = input_enable_override_en ? input_enable_override_val
                                     : !sleep_clamp;
    // Clamped to ground while disabled, tapped before any synchroniser.
    raw_digital_input = pad_in & in_en;
  end

endmodule // ppao_pin_cell

// *** hdl/ppao_portb_alt.sv ***
// Override sources for port B pins 7 to 3: clocks, serial port, compare.
`timescale 1ns/10ps
module ppao_portb_alt
  import ppao_pkg::*;
(
  // Clock source selection.
  input wire logic clk_src_intrc,
  input wire logic clk_src_ext,
  input wire logic async_timer_select,
  input wire logic external_clock_select,
  // Serial peripheral interface.
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic spi_sck_out,
  input wire logic spi_slave_out,
  input wire logic spi_master_out,
  // Timer 2 compare output.
  input wire logic t2_compare_en,
  input wire logic timer2_compare_out,
  // Pin change enable and per-pin masks.
  input wire logic pin_change_en,
  input wire logic [PORT_W-1:0] pin_change_mask,
  // Port output bits, for pull-up control of forced inputs.
  input wire logic [PORT_W-1:0] pin_output_bit,
  input wire logic global_pullup_disable,
  // Override vectors, one bit per pin.
  output logic [PORT_W-1:0] pullup_override_en,
  output logic [PORT_W-1:0] pullup_override_val,
  output logic [PORT_W-1:0] direction_override_en,
  output logic [PORT_W-1:0] direction_override_val,
  output logic [PORT_W-1:0] outvalue_override_en,
  output logic [PORT_W-1:0] outvalue_override_val,
  output logic [PORT_W-1:0] input_enable_override_en,
  output logic [PORT_W-1:0] input_enable_override_val,
  // Pins handed to the oscillators.
  output logic osc_out_pin,
  output logic osc_in_pin
);

  logic slave_sel;
  logic master_sel;

  always_comb begin
    slave_sel = spi_enable & !spi_master;
    master_sel = spi_enable & spi_master;
    // Crystal on main clock, or timer crystal without external clock.
    osc_out_pin = (!clk_src_intrc & !clk_src_ext) |
                  (async_timer_select & !external_clock_select);
    // Every main source but the RC oscillator, or the timer oscillator.
    osc_in_pin = !clk_src_intrc | async_timer_select;
    // Pins 2 to 0 carry no overrides here.
    pullup_override_en = '0;
    pullup_override_val = '0;
    direction_override_en = '0;
    direction_override_val = '0;
    outvalue_override_en = '0;
    outvalue_override_val = '0;
    input_enable_override_en = '0;
    input_enable_override_val = '0;
    // Oscillator pins: pull-up and driver off, digital input closed.
    pullup_override_en[BIT_OSC_OUT] = osc_out_pin;
    direction_override_en[BIT_OSC_OUT] = osc_out_pin;
    input_enable_override_en[BIT_OSC_OUT] = osc_out_pin |
        (pin_change_mask[BIT_OSC_OUT] & pin_change_en);
    input_enable_override_val[BIT_OSC_OUT] = !osc_out_pin;
    pullup_override_en[BIT_OSC_IN] = osc_in_pin;
    direction_override_en[BIT_OSC_IN] = osc_in_pin;
    input_enable_override_en[BIT_OSC_IN] = osc_in_pin |
        (pin_change_mask[BIT_OSC_IN] & pin_change_en);
    input_enable_override_val[BIT_OSC_IN] = !osc_in_pin;
    // Clock pin: input as slave, driven with the clock as master.
    pullup_override_en[BIT_SCK] = slave_sel;
    direction_override_en[BIT_SCK] = slave_sel;
    outvalue_override_en[BIT_SCK] = master_sel;
    outvalue_override_val[BIT_SCK] = spi_sck_out;
    // Master-in pin: input as master, driven with slave data as slave.
    pullup_override_en[BIT_MISO] = master_sel;
    direction_override_en[BIT_MISO] = master_sel;
    outvalue_override_en[BIT_MISO] = slave_sel;
    outvalue_override_val[BIT_MISO] = spi_slave_out;
    // Master-out pin: input as slave; master data or compare output.
    pullup_override_en[BIT_MOSI] = slave_sel;
    direction_override_en[BIT_MOSI] = slave_sel;
    outvalue_override_en[BIT_MOSI] = master_sel | t2_compare_en;
    outvalue_override_val[BIT_MOSI] = master_sel ? spi_master_out
                                                 : timer2_compare_out;
    // Forced inputs keep the pull-up under the output bit's control.
    for (int i = BIT_MOSI; i <= BIT_SCK; i++) begin
      pullup_override_val[i] = pin_output_bit[i] &
                               !global_pullup_disable;
    end
    // Pins 5 to 3 keep the input open while their pin change is armed.
    for (int i = BIT_MOSI; i <= BIT_SCK; i++) begin
      input_enable_override_en[i] = pin_change_mask[i] & pin_change_en;
      input_enable_override_val[i] = 1'b1;
    end
  end

endmodule // ppao_portb_alt

// *** hdl/ppao_port_top.sv ***
// Port B register bits, override combination and pad control.
// How it works
// - Without override, pull-up is on only for direction 0, output 1, enable.
// - With pull-up override set, the override value alone sets the pull-up.
// - Driver follows the direction bit unless direction override decides.
// - Driven level is override value if enabled, else the output bit.
// - Toggle override inverts the pin's output register bit.
// - Input enable follows its override, else is closed in sleep.
// - Strobes are per port; clock, sleep, pull-up disable are global.
// - Pin 7 as oscillator pin reads zero in all three bits.
// - Pin 6 as oscillator pin reads zero in all three bits.
// - Timer oscillator without external clock takes pin 7 from the port.
// - Timer oscillator select takes pin 6 from the port.
// - Main oscillator pins are not general I/O; pin 6 except RC.
// - Serial slave forces clock pin 5 to input; master uses its bit.
// - Serial master forces pin 4 to input; slave uses its bit.
// - Serial slave forces pin 3 to input; master uses its bit.
// - A serially forced input keeps pull-up under its output bit.
// - Pins 7 to 3 feed pin change sources 4 to 0, pin 3 feeding source 0.
// - Direction bit one means output, zero means input.
`timescale 1ns/10ps
module ppao_port_top
  import ppao_pkg::*;
(
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Port register access, shared by all pins of the port.
  input wire logic PORT_WR_DIR,
  input wire logic PORT_WR_OUT,
  input wire logic PORT_WR_TOGGLE,
  input wire logic [ppao_pkg::PORT_W-1:0] PORT_WR_DATA,
  input wire logic PORT_RD_DIR,
  input wire logic PORT_RD_OUT,
  input wire logic PORT_RD_PIN,
  output logic [ppao_pkg::PORT_W-1:0] PORT_RD_DATA,
  // Controls common to all ports.
  input wire logic GLOBAL_PULLUP_DISABLE,
  input wire logic SLEEP_CLAMP,
  // Clock source selection.
  input wire logic CLK_SRC_INTRC,
  input wire logic CLK_SRC_EXT,
  input wire logic ASYNC_TIMER_SELECT,
  input wire logic EXTERNAL_CLOCK_SELECT,
  // Serial peripheral interface.
  input wire logic SPI_ENABLE,
  input wire logic SPI_MASTER,
  input wire logic SPI_SCK_OUT,
  input wire logic SPI_SLAVE_OUT,
  input wire logic SPI_MASTER_OUT,
  // Timer 2 compare output.
  input wire logic T2_COMPARE_EN,
  input wire logic TIMER2_COMPARE_OUT,
  // Pin change arming.
  input wire logic PIN_CHANGE_EN,
  input wire logic [ppao_pkg::PORT_W-1:0] PIN_CHANGE_MASK,
  // Per-pin toggle override.
  input wire logic [ppao_pkg::PORT_W-1:0] TOGGLE_OVERRIDE_EN,
  // Pad side.
  input wire logic [ppao_pkg::PORT_W-1:0] PAD_IN,
  output logic [ppao_pkg::PORT_W-1:0] PAD_OE,
  output logic [ppao_pkg::PORT_W-1:0] PAD_OUT,
  output logic [ppao_pkg::PORT_W-1:0] PAD_PULLUP,
  // Alternate module side.
  output logic [ppao_pkg::PORT_W-1:0] RAW_DIGITAL_INPUT,
  output logic [ppao_pkg::PCS_W-1:0] PIN_CHANGE_SOURCE,
  output logic [1:0] ANALOG_PAD_IO_SEL
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [PORT_W-1:0] dir_r;
  logic [PORT_W-1:0] dir_nxt;
  logic [PORT_W-1:0] out_r;
  logic [PORT_W-1:0] out_nxt;
  logic [PORT_W-1:0] meta_r;
  logic [PORT_W-1:0] pin_r;
  logic [PORT_W-1:0] rd_r;
  logic [PORT_W-1:0] rd_nxt;
  logic [PORT_W-1:0] hide;
  logic [PORT_W-1:0] pullup_override_en;
  logic [PORT_W-1:0] pullup_override_val;
  logic [PORT_W-1:0] direction_override_en;
  logic [PORT_W-1:0] direction_override_val;
  logic [PORT_W-1:0] outvalue_override_en;
  logic [PORT_W-1:0] outvalue_override_val;
  logic [PORT_W-1:0] input_enable_override_en;
  logic [PORT_W-1:0] input_enable_override_val;
  logic osc_out_pin;
  logic osc_in_pin;

  // ****************************************************************
  // Alternate function sources
  // ****************************************************************
  // One instance serves the whole port; pins 2 to 0 get no overrides.
  ppao_portb_alt u_alt (
    .clk_src_intrc(CLK_SRC_INTRC),
    .clk_src_ext(CLK_SRC_EXT),
    .async_timer_select(ASYNC_TIMER_SELECT),
    .external_clock_select(EXTERNAL_CLOCK_SELECT),
    .spi_enable(SPI_ENABLE),
    .spi_master(SPI_MASTER),
    .spi_sck_out(SPI_SCK_OUT),
    .spi_slave_out(SPI_SLAVE_OUT),
    .spi_master_out(SPI_MASTER_OUT),
    .t2_compare_en(T2_COMPARE_EN),
    .timer2_compare_out(TIMER2_COMPARE_OUT),
    .pin_change_en(PIN_CHANGE_EN),
    .pin_change_mask(PIN_CHANGE_MASK),
    .pin_output_bit(out_r),
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    .pullup_override_en(pullup_override_en),
    .pullup_override_val(pullup_override_val),
    .direction_override_en(direction_override_en),
    .direction_override_val(direction_override_val),
    .outvalue_override_en(outvalue_override_en),
    .outvalue_override_val(outvalue_override_val),
    .input_enable_override_en(input_enable_override_en),
    .input_enable_override_val(input_enable_override_val),
    .osc_out_pin(osc_out_pin),
    .osc_in_pin(osc_in_pin)
  );

  // ****************************************************************
  // Per-pin override cells
  // ****************************************************************
  // Strobes are common, every override is separate per pin.
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    ppao_pin_cell u_cell (
      .pin_direction_bit(dir_r[i]),
      .pin_output_bit(out_r[i]),
      .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
      .sleep_clamp(SLEEP_CLAMP),
      .pullup_override_en(pullup_override_en[i]),
      .pullup_override_val(pullup_override_val[i]),
      .direction_override_en(direction_override_en[i]),
      .direction_override_val(direction_override_val[i]),
      .outvalue_override_en(outvalue_override_en[i]),
      .outvalue_override_val(outvalue_override_val[i]),
      .input_enable_override_en(input_enable_override_en[i]),
      .input_enable_override_val(input_enable_override_val[i]),
      .pad_in(PAD_IN[i]),
      .pad_oe(PAD_OE[i]),
      .pad_out(PAD_OUT[i]),
      .pad_pullup(PAD_PULLUP[i]),
      .raw_digital_input(RAW_DIGITAL_INPUT[i])
    );
  end

  // The pin change sources tap the raw input of pins 7 to 3.
  // Their users must synchronise them, unless used as a clock.
  assign PIN_CHANGE_SOURCE = RAW_DIGITAL_INPUT[PORT_W-1:ALT_LO];
  // Pad handed to the oscillator amplifiers: pin 7 output, pin 6 input.
  assign ANALOG_PAD_IO_SEL = {osc_out_pin, osc_in_pin};

  // ****************************************************************
  // Port registers
  // ****************************************************************
  // Write, toggle-write and toggle override may meet in one cycle;
  // the toggles apply on top of a plain write so none is lost.
  always_comb begin
    dir_nxt = PORT_WR_DIR ? PORT_WR_DATA : dir_r;
    out_nxt = PORT_WR_OUT ? PORT_WR_DATA : out_r;
    if (PORT_WR_TOGGLE) begin
      out_nxt = out_nxt ^ PORT_WR_DATA;
    end
    out_nxt = out_nxt ^ TOGGLE_OVERRIDE_EN;
  end

  // Clearing at reset floats every pin, pull-ups included.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      dir_r <= DIR_RST;
      out_r <= OUT_RST;
    end else begin
      dir_r <= dir_nxt;
      out_r <= out_nxt;
    end
  end

  // Two-stage synchroniser on the gated input; only pin_r reads meta_r.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      meta_r <= PIN_RST;
      pin_r <= PIN_RST;
    end else begin
      meta_r <= RAW_DIGITAL_INPUT;
      pin_r <= meta_r;
    end
  end

  // ****************************************************************
  // Read-back
  // ****************************************************************
  // Oscillator pins hide their register bits so software sees zero.
  always_comb begin
    hide = '0;
    hide[BIT_OSC_OUT] = osc_out_pin;
    hide[BIT_OSC_IN] = osc_in_pin;
    if (PORT_RD_DIR) begin
      rd_nxt = dir_r & ~hide;
    end else if (PORT_RD_OUT) begin
      rd_nxt = out_r & ~hide;
    end else if (PORT_RD_PIN) begin
      rd_nxt = pin_r & ~hide;
    end else begin
      rd_nxt = rd_r;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rd_r <= RD_RST;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign PORT_RD_DATA = rd_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  sequence rd_pin7_hidden_s;
    PORT_RD_PIN && !PORT_RD_DIR && !PORT_RD_OUT && osc_out_pin;
  endsequence

  sequence rd_dir6_hidden_s;
    PORT_RD_DIR && osc_in_pin;
  endsequence

  pullup_plain_a: assert property (
    PAD_PULLUP[0] == (!dir_r[0] && out_r[0] && !GLOBAL_PULLUP_DISABLE))
    else $error("plain pin pull-up wrong");

  pullup_forced_a: assert property (
    (SPI_ENABLE && !SPI_MASTER) |->
      PAD_PULLUP[BIT_SCK] == (out_r[BIT_SCK] && !GLOBAL_PULLUP_DISABLE))
    else $error("forced input pull-up wrong");

  driver_dir_a: assert property (
    PAD_OE[1] == dir_r[1])
    else $error("driver does not follow direction bit");

  out_value_a: assert property (
    (SPI_ENABLE && SPI_MASTER) |-> PAD_OUT[BIT_SCK] == SPI_SCK_OUT)
    else $error("clock pin level not from serial master");

  toggle_ovr_a: assert property (
    (TOGGLE_OVERRIDE_EN[0] && !PORT_WR_OUT && !PORT_WR_TOGGLE) |=>
      out_r[0] != $past(out_r[0]))
    else $error("toggle override did not invert output bit");

  sleep_clamp_a: assert property (
    (SLEEP_CLAMP && !input_enable_override_en[0]) |->
      !RAW_DIGITAL_INPUT[0])
    else $error("sleep did not clamp input");

  osc7_read_a: assert property (
    rd_pin7_hidden_s |=> !PORT_RD_DATA[BIT_OSC_OUT])
    else $error("oscillator pin 7 read non-zero");

  osc6_read_a: assert property (
    rd_dir6_hidden_s |=> !PORT_RD_DATA[BIT_OSC_IN])
    else $error("oscillator pin 6 read non-zero");

  osc7_detach_a: assert property (
    (ASYNC_TIMER_SELECT && !EXTERNAL_CLOCK_SELECT) |->
      !PAD_OE[BIT_OSC_OUT] && !PAD_PULLUP[BIT_OSC_OUT])
    else $error("pin 7 not detached for timer oscillator");

  osc6_detach_a: assert property (
    ASYNC_TIMER_SELECT |-> !PAD_OE[BIT_OSC_IN] && !PAD_PULLUP[BIT_OSC_IN])
    else $error("pin 6 not detached for timer oscillator");

  sck_input_a: assert property (
    (SPI_ENABLE && !SPI_MASTER) |-> !PAD_OE[BIT_SCK])
    else $error("slave clock pin not forced to input");

  miso_input_a: assert property (
    (SPI_ENABLE && SPI_MASTER) |-> !PAD_OE[BIT_MISO])
    else $error("master input pin not forced to input");

  mosi_input_a: assert property (
    (SPI_ENABLE && !SPI_MASTER) |-> !PAD_OE[BIT_MOSI])
    else $error("slave data pin not forced to input");

  sync_delay_a: assert property (
    !$past(SYS_RST, 2) && !$past(SYS_RST) |->
      pin_r == $past(RAW_DIGITAL_INPUT, SYNC_CYCLES))
    else $error("input bit not two cycles behind pad");

  pin_change_a: assert property (
    PIN_CHANGE_SOURCE[BIT_MOSI-ALT_LO] == RAW_DIGITAL_INPUT[BIT_MOSI])
    else $error("pin change source numbering wrong");

endmodule // ppao_port_top

// *** dv/ppao_pad_model.sv ***
// Pad and board model that resolves each port B pin level for the bench.
`timescale 1ns/10ps
module ppao_pad_model (
  // Clock, used only to vary the level of undriven pins.
  input wire logic clk,
  // Pad controls from the port.
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_pullup,
  // Board drivers commanded by the bench.
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved pin levels.
  output logic [7:0] pad_in
);
  // ****************************************************************
  // Pin resolution
  // ****************************************************************
  // A floating pin changes every cycle, so a design that reads it
  // cannot pass by a lucky settling of an unknown value.
  logic [7:0] flip_r = 8'h55;

  // Undriven pattern advances once a cycle.
  always @(posedge clk) begin
    flip_r <= ~flip_r;
  end

  // The port driver wins, then the board driver, then the pull-up.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pullup[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = flip_r[i];
      end
    end
  end
endmodule // ppao_pad_model

// *** dv/port_pin_alternate_override_bench.sv ***
// Self-checking bench for the port B pin override block.
`timescale 1ns/10ps
module port_pin_alternate_override_bench
  import ppao_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk, rst, wd, wo, wt, rdd, rdo, rdp, gpd, slp, intrc, ext;
  logic as_s, tmr_ext, spe, mstr, sck_o, sl_o, ms_o, t2e, t2o, pce;
  logic [PORT_W-1:0] wdat, rdat, pcm, tog, pad_in, oe, po, pu, raw;
  logic [PORT_W-1:0] ext_en, ext_val;
  logic [PCS_W-1:0] pcs;
  logic [1:0] osc_sel;
  int n_fail, compares, cyc;

  ppao_port_top uut (
    .CORE_CLK(clk), .SYS_RST(rst), .PORT_WR_DIR(wd), .PORT_WR_OUT(wo),
    .PORT_WR_TOGGLE(wt), .PORT_WR_DATA(wdat), .PORT_RD_DIR(rdd),
    .PORT_RD_OUT(rdo), .PORT_RD_PIN(rdp), .PORT_RD_DATA(rdat),
    .GLOBAL_PULLUP_DISABLE(gpd), .SLEEP_CLAMP(slp), .CLK_SRC_INTRC(intrc),
    .CLK_SRC_EXT(ext), .ASYNC_TIMER_SELECT(as_s),
    .EXTERNAL_CLOCK_SELECT(tmr_ext), .SPI_ENABLE(spe), .SPI_MASTER(mstr),
    .SPI_SCK_OUT(sck_o), .SPI_SLAVE_OUT(sl_o), .SPI_MASTER_OUT(ms_o),
    .T2_COMPARE_EN(t2e), .TIMER2_COMPARE_OUT(t2o), .PIN_CHANGE_EN(pce),
    .PIN_CHANGE_MASK(pcm), .TOGGLE_OVERRIDE_EN(tog), .PAD_IN(pad_in),
    .PAD_OE(oe), .PAD_OUT(po), .PAD_PULLUP(pu), .RAW_DIGITAL_INPUT(raw),
    .PIN_CHANGE_SOURCE(pcs), .ANALOG_PAD_IO_SEL(osc_sel));

  ppao_pad_model pads (.clk(clk), .pad_oe(oe), .pad_out(po),
    .pad_pullup(pu), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // ****************************************************************
  // Clock, watchdog and shared tasks
  // ****************************************************************
  // Free-running core clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The whole run needs under a hundred cycles; 3000 means a hang.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Inputs always change one nanosecond after the rising edge.
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write strobe {dir, out, toggle} for a single edge. An idle edge
  // follows, so back-to-back calls never set a strobe twice at once.
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    {wd, wo, wt} = s;
    wdat = d;
    step();
    {wd, wo, wt} = 3'b000;
    step();
  endtask

  // One read select {dir, out, pin}; data is registered at that edge.
  task automatic rd(input logic [2:0] s, output logic [7:0] q);
    {rdd, rdo, rdp} = s;
    step();
    {rdd, rdo, rdp} = 3'b000;
    q = rdat;
    step();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_plain();
    logic [7:0] q;
    chk(oe, 8'h00);
    wr(3'b100, 8'h0F);
    wr(3'b010, 8'h35);
    chk(oe, 8'h0F);
    chk(po & oe, 8'h05);
    chk(pu, 8'h30);
    gpd = 1'b1;
    step();
    chk(pu, 8'h00);
    gpd = 1'b0;
    rd(3'b100, q);
    chk(q, 8'h0F);
    rd(3'b010, q);
    chk(q, 8'h35);
  endtask

  task automatic t_toggle();
    wr(3'b100, 8'hFF);
    wr(3'b001, 8'hA5);
    chk(po, 8'h90);
    tog = 8'h03;
    step();
    chk(po, 8'h93);
    // A plain write and a toggle override in one cycle add up.
    tog = 8'h02;
    wo = 1'b1;
    wdat = 8'h00;
    step();
    {wo, tog} = 9'h000;
    chk(po, 8'h02);
  endtask

  task automatic t_osc();
    logic [7:0] q;
    wr(3'b010, 8'hFF);
    as_s = 1'b1;
    step();
    chk(oe & 8'hC0, 8'h00);
    chk({6'h00, osc_sel}, 8'h03);
    chk(pu & 8'hC0, 8'h00);
    rd(3'b100, q);
    chk(q, 8'h3F);
    rd(3'b010, q);
    chk(q, 8'h3F);
    // Pins 5 to 0 drive high, so only the hidden bits read zero.
    rd(3'b001, q);
    chk(q, 8'h3F);
    tmr_ext = 1'b1;
    step();
    chk(oe & 8'hC0, 8'h80);
    chk({6'h00, osc_sel}, 8'h01);
    {as_s, tmr_ext, intrc} = 3'b000;
    step();
    chk({6'h00, osc_sel}, 8'h03);
    chk(oe & 8'hC0, 8'h00);
    ext = 1'b1;
    step();
    chk(oe & 8'hC0, 8'h80);
    chk({6'h00, osc_sel}, 8'h01);
    {intrc, ext} = 2'b10;
  endtask

  task automatic t_spi();
    wr(3'b100, 8'h10);
    wr(3'b010, 8'h38);
    {spe, mstr, sl_o} = 3'b100;
    step();
    chk(oe & 8'h38, 8'h10);
    chk(po & 8'h10, 8'h00);
    sl_o = 1'b1;
    step();
    chk(po & 8'h10, 8'h10);
    chk(pu & 8'h38, 8'h28);
    gpd = 1'b1;
    step();
    chk(pu & 8'h38, 8'h00);
    gpd = 1'b0;
    {mstr, sck_o, ms_o} = 3'b110;
    wr(3'b100, 8'h38);
    chk(oe & 8'h38, 8'h28);
    chk(po & 8'h28, 8'h20);
    chk(pu & 8'h38, 8'h10);
    ms_o = 1'b1;
    step();
    chk(po & 8'h28, 8'h28);
    {spe, mstr, sck_o, ms_o, sl_o} = 5'b00000;
  endtask

  task automatic t_compare();
    wr(3'b100, 8'h08);
    {t2e, t2o} = 2'b11;
    step();
    chk(po & oe & 8'h08, 8'h08);
    t2o = 1'b0;
    step();
    chk(po & oe & 8'h08, 8'h00);
    t2e = 1'b0;
  endtask

  task automatic t_input();
    logic [7:0] q;
    wr(3'b100, 8'h00);
    {ext_en, ext_val} = {8'hFF, 8'hC9};
    step();
    chk(raw, 8'hC9);
    chk({3'b000, pcs}, 8'h19);
    step();
    step();
    rd(3'b001, q);
    chk(q, 8'hC9);
    slp = 1'b1;
    step();
    chk(raw, 8'h00);
    {pce, pcm} = {1'b1, 8'h28};
    step();
    chk(raw, 8'h08);
    chk({3'b000, pcs}, 8'h01);
    {slp, pce, pcm, ext_en} = 18'h00000;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // All inputs start defined; the clock source is the RC oscillator
  // so pins 7 and 6 begin as ordinary port pins.
  initial begin
    {rst, wd, wo, wt, rdd, rdo, rdp, gpd, slp, ext} = 10'h200;
    {as_s, tmr_ext, spe, mstr, sck_o, sl_o, ms_o, t2e, t2o, pce} = 10'h000;
    intrc = 1'b1;
    {wdat, pcm, tog, ext_en, ext_val} = 40'h00_0000_0000;
    n_fail = 0;
    compares = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    t_plain();
    t_toggle();
    t_osc();
    t_spi();
    t_compare();
    t_input();
    report_and_stop();
  end
endmodule // port_pin_alternate_override_bench
